// *** common/rscl_pkg.sv ***
// Package for the reset strap configuration latch.
// Assumes a single 10 MHz clock and one Avalon-MM slave port.
package rscl_pkg;

    // ----------------------------------------------------------------
    // Register map: byte offsets on the 4-bit address port
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_STRAPS_ADDR = 4'h0;
    localparam logic [3:0] REG_DECODE_ADDR = 4'h4;
    localparam logic [3:0] REG_CLOCKS_ADDR = 4'h8;
    localparam logic [3:0] REG_CTRL_ADDR = 4'hc;

    // ----------------------------------------------------------------
    // Strap bit positions in the raw strap word
    // ----------------------------------------------------------------
    localparam int STRAP_MEM_FREQ = 0;
    localparam int STRAP_HOST_HI = 1;
    localparam int STRAP_HOST_LO = 2;
    localparam int STRAP_QUEUE = 3;
    localparam int STRAP_FLOAT = 4;
    localparam int STRAP_XOR = 5;
    localparam int STRAP_KICKER = 6;
    localparam int STRAP_COUNT = 7;
    localparam logic [6:0] STRAP_RESET_VALUE = 7'h7f;

    // ----------------------------------------------------------------
    // Decode register fields
    // ----------------------------------------------------------------
    localparam int DEC_HOST_LSB = 0;
    localparam int DEC_MEM_LSB = 8;
    localparam int DEC_QUEUE_LSB = 16;
    localparam int DEC_FLOAT_BIT = 20;
    localparam int DEC_XOR_BIT = 21;
    localparam int DEC_KICKER_BIT = 22;
    localparam int DEC_VALID_BIT = 31;

    // ----------------------------------------------------------------
    // Frequencies in MHz and queue depths
    // ----------------------------------------------------------------
    localparam logic [7:0] FREQ_133_MHZ = 8'h85;
    localparam logic [7:0] FREQ_100_MHZ = 8'h64;
    localparam logic [7:0] FREQ_66_MHZ = 8'h42;
    localparam logic [7:0] FREQ_48_MHZ = 8'h30;
    localparam logic [3:0] QUEUE_DEEP = 4'h4;
    localparam logic [3:0] QUEUE_SHALLOW = 4'h1;

    // ----------------------------------------------------------------
    // Clock register fields and control register fields
    // ----------------------------------------------------------------
    localparam int CLK_HUB_LSB = 0;
    localparam int CLK_DISP_LSB = 8;
    localparam int CLK_SYSMEM_LSB = 16;
    localparam int CLK_DIV_LSB = 24;
    localparam int CTRL_CACHE_EN_BIT = 0;
    localparam logic [7:0] CACHE_DIV_RESET = 8'h01;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    typedef enum logic [1:0] {
        RSCL_SAMPLE = 2'b00,
        RSCL_LATCH = 2'b01,
        RSCL_HOLD = 2'b11
    } rscl_state_type;

endpackage

// *** src/rscl_top.sv ***
// Reset strap configuration latch: samples board straps on the shared
// memory pins during reset, then holds and decodes them, generates the
// display cache transmit and loop-out clocks, and exposes it all over
// an Avalon-MM slave. Strap pins are asynchronous and are synchronised.
`timescale 1ns/10ps
module rscl_top #(
    parameter int CLOCK_HZ = 10000000
)(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic mem_freq_strap_pin_in,
    input wire logic mem_col_strobe_pin_in,
    input wire logic mem_write_enable_pin_in,
    input wire logic queue_depth_strap_pin_in,
    input wire logic float_all_strap_pin_in,
    input wire logic mem_row_strobe_pin_in,
    input wire logic kicker_strap_pin_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic [7:0] host_freq_mhz_out,
    output logic [7:0] mem_freq_mhz_out,
    output logic [3:0] host_order_queue_out,
    output logic float_all_out,
    output logic xor_test_out,
    output logic kicker_enable_out,
    output logic config_valid_out,
    output logic [1:0] cache_tx_clocks_out,
    output logic cache_loop_out_clock_out
);

    // ----------------------------------------------------------------
    // Strap synchroniser
    // ----------------------------------------------------------------
    logic [6:0] strap_raw;
    logic [6:0] strap_meta;
    logic [6:0] strap_sync;
    logic [6:0] strap_held;
    rscl_pkg::rscl_state_type state;
    rscl_pkg::rscl_state_type next_state;

    assign strap_raw = {kicker_strap_pin_in, mem_row_strobe_pin_in, float_all_strap_pin_in,
                        queue_depth_strap_pin_in, mem_write_enable_pin_in,
                        mem_col_strobe_pin_in, mem_freq_strap_pin_in};

    // Straps keep clocking through reset so the last level before release is
    // what gets latched; pull-ups make the reset value all ones.
    always_ff @(posedge clk_in)
    begin
        strap_meta <= strap_raw;
        strap_sync <= strap_meta;
    end

    // ----------------------------------------------------------------
    // Capture sequencing
    // ----------------------------------------------------------------
    always_comb
    begin
        case (state)
            rscl_pkg::RSCL_SAMPLE: next_state = rscl_pkg::RSCL_LATCH;
            rscl_pkg::RSCL_LATCH: next_state = rscl_pkg::RSCL_HOLD;
            rscl_pkg::RSCL_HOLD: next_state = rscl_pkg::RSCL_HOLD;
            default: next_state = rscl_pkg::RSCL_SAMPLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            state <= rscl_pkg::RSCL_SAMPLE;
        else
            state <= next_state;
    end

    // The synchroniser output at the first edge after release still reflects the
    // pins as they stood under reset, before the device drives them.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            strap_held <= rscl_pkg::STRAP_RESET_VALUE;
        else if (state == rscl_pkg::RSCL_SAMPLE)
            strap_held <= strap_sync;
        // no other load path, so later pin activity is ignored
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic [7:0] next_host_freq;

    always_comb
    begin
        if (strap_held[rscl_pkg::STRAP_HOST_HI])
            next_host_freq = rscl_pkg::FREQ_133_MHZ;
        else if (strap_held[rscl_pkg::STRAP_HOST_LO])
            next_host_freq = rscl_pkg::FREQ_100_MHZ;
        else
            next_host_freq = rscl_pkg::FREQ_66_MHZ;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            host_freq_mhz_out <= rscl_pkg::FREQ_133_MHZ;
            mem_freq_mhz_out <= rscl_pkg::FREQ_133_MHZ;
            host_order_queue_out <= rscl_pkg::QUEUE_DEEP;
            float_all_out <= 1'b0;
            xor_test_out <= 1'b0;
            kicker_enable_out <= 1'b1;
            config_valid_out <= 1'b0;
        end
        else
        begin
            host_freq_mhz_out <= next_host_freq;
            mem_freq_mhz_out <= strap_held[rscl_pkg::STRAP_MEM_FREQ] ?
                rscl_pkg::FREQ_133_MHZ : rscl_pkg::FREQ_100_MHZ;
            host_order_queue_out <= strap_held[rscl_pkg::STRAP_QUEUE] ?
                rscl_pkg::QUEUE_DEEP : rscl_pkg::QUEUE_SHALLOW;
            float_all_out <= !strap_held[rscl_pkg::STRAP_FLOAT];
            xor_test_out <= !strap_held[rscl_pkg::STRAP_XOR];
            kicker_enable_out <= strap_held[rscl_pkg::STRAP_KICKER];
            config_valid_out <= (state == rscl_pkg::RSCL_HOLD);
        end
    end

    // ----------------------------------------------------------------
    // Display cache clock generation
    // ----------------------------------------------------------------
    logic cache_enable;
    logic [7:0] cache_div;
    logic [7:0] cache_count;
    logic cache_phase;

    // Divider toggles every div cycles, giving clk/(2*div); a real part would use a PLL, this keeps
    // one clock domain and a registered, glitch-free output.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cache_count <= 8'h00;
            cache_phase <= 1'b0;
        end
        else if (!cache_enable || float_all_out)
        begin
            cache_count <= 8'h00;
            cache_phase <= 1'b0;
        end
        else if (cache_count + 8'h01 >= cache_div)
        begin
            cache_count <= 8'h00;
            cache_phase <= !cache_phase;
        end
        else
            cache_count <= cache_count + 8'h01;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cache_tx_clocks_out <= 2'b00;
            cache_loop_out_clock_out <= 1'b0;
        end
        else
        begin
            cache_tx_clocks_out <= {cache_phase, cache_phase};
            cache_loop_out_clock_out <= cache_phase;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait state on reads, none on writes; reads registered one cycle
    // ----------------------------------------------------------------
    logic rd_done;
    logic [31:0] decode_word;
    logic [31:0] clocks_word;
    logic [31:0] next_readdata;

    always_comb
    begin
        decode_word = 32'h00000000;
        decode_word[rscl_pkg::DEC_HOST_LSB +: 8] = host_freq_mhz_out;
        decode_word[rscl_pkg::DEC_MEM_LSB +: 8] = mem_freq_mhz_out;
        decode_word[rscl_pkg::DEC_QUEUE_LSB +: 4] = host_order_queue_out;
        decode_word[rscl_pkg::DEC_FLOAT_BIT] = float_all_out;
        decode_word[rscl_pkg::DEC_XOR_BIT] = xor_test_out;
        decode_word[rscl_pkg::DEC_KICKER_BIT] = kicker_enable_out;
        decode_word[rscl_pkg::DEC_VALID_BIT] = config_valid_out;
        clocks_word = 32'h00000000;
        clocks_word[rscl_pkg::CLK_HUB_LSB +: 8] = rscl_pkg::FREQ_66_MHZ;
        clocks_word[rscl_pkg::CLK_DISP_LSB +: 8] = rscl_pkg::FREQ_48_MHZ;
        clocks_word[rscl_pkg::CLK_SYSMEM_LSB +: 8] = mem_freq_mhz_out;
        clocks_word[rscl_pkg::CLK_DIV_LSB +: 8] = cache_div;
        case (avs_address_in)
            rscl_pkg::REG_STRAPS_ADDR: next_readdata = {25'h0000000, strap_held};
            rscl_pkg::REG_DECODE_ADDR: next_readdata = decode_word;
            rscl_pkg::REG_CLOCKS_ADDR: next_readdata = clocks_word;
            rscl_pkg::REG_CTRL_ADDR: next_readdata = {31'h00000000, cache_enable};
            default: next_readdata = rscl_pkg::UNMAPPED_READ;
        endcase
    end

    assign avs_waitrequest_out = avs_read_in && !rd_done;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rd_done <= 1'b0;
            avs_readdata_out <= 32'h00000000;
        end
        else
        begin
            rd_done <= avs_read_in && !rd_done;
            if (avs_read_in && !rd_done)
                avs_readdata_out <= next_readdata;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cache_enable <= 1'b0;
            cache_div <= rscl_pkg::CACHE_DIV_RESET;
        end
        else if (avs_write_in && avs_address_in == rscl_pkg::REG_CTRL_ADDR)
        begin
            if (avs_byteenable_in[0])
                cache_enable <= avs_writedata_in[rscl_pkg::CTRL_CACHE_EN_BIT];
        end
        else if (avs_write_in && avs_address_in == rscl_pkg::REG_CLOCKS_ADDR)
        begin
            if (avs_byteenable_in[3] && avs_writedata_in[31:24] != 8'h00)
                cache_div <= avs_writedata_in[31:24];
        end
    end

endmodule // rscl_top

// *** sim/rscl_properties.sv ***
// Checker for the strap latch: decode, hold and bus timing.
// Assumes straps stay steady while reset is low.
`timescale 1ns/10ps
module rscl_properties (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic mem_freq_strap_pin_in,
    input wire logic mem_col_strobe_pin_in,
    input wire logic mem_write_enable_pin_in,
    input wire logic queue_depth_strap_pin_in,
    input wire logic float_all_strap_pin_in,
    input wire logic mem_row_strobe_pin_in,
    input wire logic kicker_strap_pin_in,
    input wire logic avs_read_in,
    input wire logic avs_waitrequest_out,
    input wire logic [7:0] host_freq_mhz_out,
    input wire logic [7:0] mem_freq_mhz_out,
    input wire logic [3:0] host_order_queue_out,
    input wire logic float_all_out,
    input wire logic xor_test_out,
    input wire logic kicker_enable_out,
    input wire logic config_valid_out,
    input wire logic [1:0] cache_tx_clocks_out,
    input wire logic cache_loop_out_clock_out
);
    logic [6:0] cap;
    logic [7:0] exp_host;
    // Pin levels seen on the last reset edges stand for the board settings
    always_ff @(posedge clk_in)
        if (!resetn_in)
            cap <= {kicker_strap_pin_in, mem_row_strobe_pin_in, float_all_strap_pin_in,
                queue_depth_strap_pin_in, mem_write_enable_pin_in, mem_col_strobe_pin_in,
                mem_freq_strap_pin_in};
    assign exp_host = cap[1] ? 8'h85 : (cap[2] ? 8'h64 : 8'h42);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_release;
        $rose(resetn_in);
    endsequence
    sequence s_valid;
        ##[1:4] config_valid_out;
    endsequence
    sequence s_rd_wait;
        avs_read_in && avs_waitrequest_out;
    endsequence
    a_valid_after_release: assert property (s_release |-> s_valid)
        else $error("config valid late after reset release");
    a_mem_decode: assert property (config_valid_out |->
        mem_freq_mhz_out == (cap[0] ? 8'h85 : 8'h64)) else $error("memory frequency wrong");
    a_host_decode: assert property (config_valid_out |-> host_freq_mhz_out == exp_host)
        else $error("host frequency wrong");
    a_queue_decode: assert property (config_valid_out |->
        host_order_queue_out == (cap[3] ? 4'h4 : 4'h1)) else $error("queue depth wrong");
    a_float_xor: assert property (config_valid_out |->
        float_all_out == !cap[4] && xor_test_out == !cap[5]) else $error("test modes wrong");
    a_kicker_decode: assert property (config_valid_out |-> kicker_enable_out == cap[6])
        else $error("kicker enable wrong");
    a_hold_config: assert property (config_valid_out && $past(config_valid_out) |->
        $stable({host_freq_mhz_out, mem_freq_mhz_out, host_order_queue_out, float_all_out,
        xor_test_out, kicker_enable_out})) else $error("settings moved after release");
    a_cache_pair: assert property (cache_tx_clocks_out == {2{cache_loop_out_clock_out}})
        else $error("cache clocks out of phase");
    a_read_answer: assert property (s_rd_wait |=> !avs_waitrequest_out)
        else $error("read wait longer than one cycle");
endmodule // rscl_properties

// *** sim/rscl_board_model.sv ***
// Board side: strap resistors and the system reset driver.
// Once the device leaves reset the shared pins carry bus traffic.
`timescale 1ns/10ps
module rscl_board_model (
    input wire logic clk_in,
    input wire logic pci_resetn_in,
    input wire logic [6:0] strap_set_in,
    output logic resetn_out = 1'b0,
    output logic [6:0] strap_pins_out = 7'h7f
);
    logic [6:0] traffic = 7'h00;
    always_ff @(posedge clk_in)
        resetn_out <= pci_resetn_in;
    // Traffic flips every cycle so a late sample of the pins sees the inverted straps only on alternate cycles
    always_ff @(posedge clk_in)
        traffic <= resetn_out ? ~traffic : ~strap_set_in;
    always_ff @(posedge clk_in)
        strap_pins_out <= resetn_out ? traffic : strap_set_in;
endmodule // rscl_board_model

// *** sim/test_reset_strap_config_latch.sv ***
// Self-checking bench for the strap latch over its register port.
// The board model supplies straps and reset; the checker is bound below.
`timescale 1ns/10ps
module test_reset_strap_config_latch;
    logic clk_in = 1'b0;
    logic pci_resetn = 1'b0;
    logic [6:0] strap_set = 7'h7f;
    logic [6:0] pins;
    logic resetn;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic wait_req;
    logic valid;
    logic loop_clk;
    logic [31:0] notes[$];
    logic [6:0] sets[6];
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    rscl_board_model i_rscl_board_model (.clk_in, .pci_resetn_in(pci_resetn),
        .strap_set_in(strap_set), .resetn_out(resetn), .strap_pins_out(pins));
    rscl_top i_rscl_top (.clk_in, .resetn_in(resetn), .mem_freq_strap_pin_in(pins[0]),
        .mem_col_strobe_pin_in(pins[1]), .mem_write_enable_pin_in(pins[2]),
        .queue_depth_strap_pin_in(pins[3]), .float_all_strap_pin_in(pins[4]),
        .mem_row_strobe_pin_in(pins[5]), .kicker_strap_pin_in(pins[6]),
        .avs_address_in(address), .avs_read_in(read), .avs_write_in(write),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_req), .host_freq_mhz_out(), .mem_freq_mhz_out(),
        .host_order_queue_out(), .float_all_out(), .xor_test_out(), .kicker_enable_out(),
        .config_valid_out(valid), .cache_tx_clocks_out(),
        .cache_loop_out_clock_out(loop_clk));
    initial
        forever #50 clk_in = ~clk_in;
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            bad_count++;
            complete_run();
        end
    end
    // --------------------------------------------------------------
    // Bus tasks and read monitor
    // --------------------------------------------------------------
    always @(posedge clk_in)
        if (read && !wait_req)
        begin
            checked++;
            if (rdata !== notes.pop_front())
            begin
                bad_count++;
                $display("FAIL %0t read data %h", $time, rdata);
            end
        end
    task automatic bus_access(input logic rd, input logic [3:0] addr, input logic [31:0] d);
        if (rd)
            notes.push_back(d);
        address <= addr;
        wdata <= d;
        read <= rd;
        write <= !rd;
        @(posedge clk_in);
        while (wait_req !== 1'b0)
            @(posedge clk_in);
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic board_reset(input logic [6:0] s);
        strap_set <= s;
        pci_resetn <= 1'b0;
        repeat (3) @(posedge clk_in);
        pci_resetn <= 1'b1;
        while (valid !== 1'b1)
            @(posedge clk_in);
    endtask
    function automatic logic [31:0] decode_word(input logic [6:0] s);
        return {1'b1, 8'h0, s[6], !s[5], !s[4], s[3] ? 4'h4 : 4'h1, s[0] ? 8'h85 : 8'h64,
            s[1] ? 8'h85 : (s[2] ? 8'h64 : 8'h42)};
    endfunction
    initial
    begin
        int t;
        logic last;
        void'($urandom(12));
        @(posedge clk_in);
        sets = '{7'h7f, 7'h00, 7'h02, 7'h04, 7'h00, 7'h7f};
        sets[4] = 7'($urandom);
        for (int i = 0; i < 6; i++)
        begin
            board_reset(sets[i]);
            bus_access(1'b1, 4'h0, {25'h0, sets[i]});
            bus_access(1'b1, 4'h4, decode_word(sets[i]));
            repeat (7) @(posedge clk_in);
            bus_access(1'b1, 4'h4, decode_word(sets[i]));
        end
        bus_access(1'b0, 4'h0, 32'h0);
        bus_access(1'b1, 4'h0, 32'h7f);
        bus_access(1'b1, 4'h2, 32'h0);
        bus_access(1'b1, 4'h8, 32'h01853042);
        bus_access(1'b0, 4'h8, 32'h03000000);
        bus_access(1'b0, 4'h8, 32'h00000000);
        bus_access(1'b1, 4'h8, 32'h03853042);
        bus_access(1'b0, 4'hc, 32'h1);
        bus_access(1'b1, 4'hc, 32'h1);
        t = 0;
        last = loop_clk;
        repeat (24)
        begin
            @(posedge clk_in);
            t += (loop_clk !== last);
            last = loop_clk;
        end
        checked++;
        if (t != 8)
        begin
            bad_count++;
            $display("FAIL %0t cache clock toggles %0d", $time, t);
        end
        complete_run();
    end
endmodule // test_reset_strap_config_latch
bind rscl_top rscl_properties i_rscl_properties (.clk_in, .resetn_in,
    .mem_freq_strap_pin_in, .mem_col_strobe_pin_in, .mem_write_enable_pin_in,
    .queue_depth_strap_pin_in, .float_all_strap_pin_in, .mem_row_strobe_pin_in,
    .kicker_strap_pin_in, .avs_read_in, .avs_waitrequest_out, .host_freq_mhz_out,
    .mem_freq_mhz_out, .host_order_queue_out, .float_all_out, .xor_test_out,
    .kicker_enable_out, .config_valid_out, .cache_tx_clocks_out, .cache_loop_out_clock_out);
